// *** miiph_consts.svh ***
/*
 Constants of the MII data path: clock division, field widths, reset values.
 Assumes a 40 MHz system clock; included by the package, miiph_clkgen and miiph_top.
*/
// Operation
// - Transmit nibble bit zero is least significant
// - PHY sources transmit clock 2.5/25 MHz (the divider gives 2.5/20 MHz from 40 MHz)
// - Receive nibble synchronous, bit zero least significant
// - Receive valid marks exactly valid data cycles
// - Receive error flags detected receive errors
// - Receive clock 25 or 2.5 MHz (the divider gives 20 or 2.5 MHz from 40 MHz)
// - Collision high while collision persists
// - Collision unclocked, inactive in full duplex
// - Half duplex: carrier on transmit or receive
// - Full duplex: carrier only on receive
// - Carrier rises async, falls on receive clock
`ifndef MIIPH_CONSTS_SVH
`define MIIPH_CONSTS_SVH
`define MIIPH_SYS_MHZ 40
`define MIIPH_FAST_MHZ_X10 250
`define MIIPH_SLOW_MHZ_X10 25
// Half periods in system cycles, rounded down; the fast one at least one
`define MIIPH_HALF_FAST (((`MIIPH_SYS_MHZ * 10) / (2 * `MIIPH_FAST_MHZ_X10)) < 1 ? 1 : \
   ((`MIIPH_SYS_MHZ * 10) / (2 * `MIIPH_FAST_MHZ_X10)))
`define MIIPH_HALF_SLOW ((`MIIPH_SYS_MHZ * 10) / (2 * `MIIPH_SLOW_MHZ_X10))
`define MIIPH_DIV_W 8
`define MIIPH_NIB_W 4
`define MIIPH_NIB_RST 4'h0
`endif

// *** miiph_pkg.sv ***
/*
 Types of the MII data path.
 Assumes miiph_consts.svh is on the include path.
*/
`include "miiph_consts.svh"
package miiph_pkg;
   typedef enum logic [1:0]
   {
      MIIPH_IDLE = 2'b00,
      MIIPH_DATA = 2'b01,
      MIIPH_ERR = 2'b10
   } miiph_rx_t;
endpackage : miiph_pkg

// *** miiph_clkgen.sv ***
/*
 Divider producing one MII clock from the system clock, with a rising-edge strobe.
 Assumes a synchronous active-low reset on the system clock.
*/
`timescale 1ns/1ps
`include "miiph_consts.svh"
module miiph_clkgen
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fast,
   output logic mii_clk,
   output logic rise
);
   logic [`MIIPH_DIV_W-1:0] cnt_r;
   logic [`MIIPH_DIV_W-1:0] cnt_nxt;
   logic clk_r;
   logic clk_nxt;
   logic [`MIIPH_DIV_W-1:0] half;

   always_comb
   begin
      half = fast ? `MIIPH_DIV_W'(`MIIPH_HALF_FAST) : `MIIPH_DIV_W'(`MIIPH_HALF_SLOW);
      cnt_nxt = cnt_r + 1'b1;
      clk_nxt = clk_r;
      if (cnt_nxt >= half)
      begin
         cnt_nxt = '0;
         clk_nxt = ~clk_r;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_r <= '0;
         clk_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         clk_r <= clk_nxt;
      end
   end

   assign mii_clk = clk_r;
   assign rise = (cnt_nxt == '0) && !clk_r;
endmodule : miiph_clkgen

// *** miiph_top.sv ***
/*
 PHY side of the MII data path: sources both MII clocks, samples the MAC's
 transmit nibbles, presents receive nibbles, and drives collision and carrier.
 Assumes the line side supplies received nibbles and status as same-clock
 logic; TX_EN and TXD come from the MAC pins.
 Speed and duplex pins pass the same three-stage filter as TX_EN.
*/
`timescale 1ns/1ps
`include "miiph_consts.svh"
module miiph_top
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic SPEED_100,
   input wire logic FULL_DUPLEX,
   output logic TX_CLK,
   input wire logic TX_EN,
   input wire logic [3:0] TXD,
   output logic RX_CLK,
   output logic [3:0] RXD,
   output logic RX_DV,
   output logic RX_ER,
   output logic COL,
   output logic CRS,
   output logic [3:0] LINE_TX_NIBBLE,
   output logic LINE_TX_VALID,
   output logic LINE_TX_ACTIVE,
   input wire logic [3:0] LINE_RX_NIBBLE,
   input wire logic LINE_RX_VALID,
   input wire logic LINE_RX_ERROR,
   input wire logic LINE_CARRIER,
   input wire logic LINE_COLLISION
);
   logic tx_rise;
   logic rx_clk_i;

   // Speed and duplex pins: same three-stage filter as the transmit pins
   logic [1:0] c1_r, c2_r, c3_r, cfg_r;
   logic [1:0] c1_nxt, c2_nxt, c3_nxt, cfg_nxt;
   logic fast_s;
   logic full_s;

   always_comb
   begin
      c1_nxt = {SPEED_100, FULL_DUPLEX};
      c2_nxt = c1_r;
      c3_nxt = c2_r;
      cfg_nxt = (c2_r == c3_r) ? c3_r : cfg_r;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         c1_r <= 2'h0;
         c2_r <= 2'h0;
         c3_r <= 2'h0;
         cfg_r <= 2'h0;
      end
      else
      begin
         c1_r <= c1_nxt;
         c2_r <= c2_nxt;
         c3_r <= c3_nxt;
         cfg_r <= cfg_nxt;
      end
   end

   assign fast_s = cfg_r[1];
   assign full_s = cfg_r[0];

   miiph_clkgen u_txclk
   (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .fast(fast_s),
      .mii_clk(TX_CLK),
      .rise(tx_rise)
   );

   miiph_clkgen u_rxclk
   (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .fast(fast_s),
      .mii_clk(rx_clk_i),
      .rise()
   );
   assign RX_CLK = rx_clk_i;

   // Transmit pins: three stages, change accepted when stages two and three agree
   logic [4:0] s1_r, s2_r, s3_r, s1_nxt, s2_nxt, s3_nxt;
   logic [4:0] tx_q_r, tx_q_nxt;
   logic [3:0] ltx_d_r, ltx_d_nxt;
   logic ltx_v_r, ltx_v_nxt;

   always_comb
   begin
      s1_nxt = {TX_EN, TXD};
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      tx_q_nxt = (s2_r == s3_r) ? s3_r : tx_q_r;
      ltx_d_nxt = ltx_d_r;
      ltx_v_nxt = 1'b0;
      // Sample on our rising edge; MAC changes data with TX_CLK
      if (tx_rise)
      begin
         ltx_v_nxt = tx_q_r[4];
         if (tx_q_r[4])
            ltx_d_nxt = tx_q_r[3:0];
         else
            ltx_d_nxt = `MIIPH_NIB_RST;
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         s1_r <= 5'h00;
         s2_r <= 5'h00;
         s3_r <= 5'h00;
         tx_q_r <= 5'h00;
         ltx_d_r <= `MIIPH_NIB_RST;
         ltx_v_r <= 1'b0;
      end
      else
      begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         tx_q_r <= tx_q_nxt;
         ltx_d_r <= ltx_d_nxt;
         ltx_v_r <= ltx_v_nxt;
      end
   end

   assign LINE_TX_NIBBLE = ltx_d_r;
   assign LINE_TX_VALID = ltx_v_r;
   assign LINE_TX_ACTIVE = tx_q_r[4];

   // Receive path: outputs change one cycle after RX_CLK falls; stable at MAC's rising edge when slow, change on that edge when fast
   miiph_pkg::miiph_rx_t st_r, st_nxt;
   logic [3:0] rxd_r, rxd_nxt;
   logic rxdv_r, rxdv_nxt, rxer_r, rxer_nxt;
   logic crs_r, crs_nxt, col_r, col_nxt;
   logic rx_fall;
   logic clk_d_r;

   assign rx_fall = clk_d_r && !rx_clk_i;

   always_comb
   begin
      st_nxt = st_r;
      rxd_nxt = rxd_r;
      rxdv_nxt = rxdv_r;
      rxer_nxt = rxer_r;
      crs_nxt = crs_r;
      // Collision follows the line, no MII clock; masked in full duplex
      col_nxt = LINE_COLLISION && !full_s;
      // Carrier rises at once, falls only on an RX_CLK edge
      if (LINE_CARRIER || (!full_s && tx_q_r[4]))
         crs_nxt = 1'b1;
      else if (rx_fall)
         crs_nxt = 1'b0;
      if (rx_fall)
      begin
         case (st_r)
            miiph_pkg::MIIPH_IDLE:
               if (LINE_RX_VALID && LINE_RX_ERROR)
                  st_nxt = miiph_pkg::MIIPH_ERR;
               else if (LINE_RX_VALID)
                  st_nxt = miiph_pkg::MIIPH_DATA;
            miiph_pkg::MIIPH_DATA:
               if (!LINE_RX_VALID)
                  st_nxt = miiph_pkg::MIIPH_IDLE;
               else if (LINE_RX_ERROR)
                  st_nxt = miiph_pkg::MIIPH_ERR;
            miiph_pkg::MIIPH_ERR:
               if (!LINE_RX_VALID)
                  st_nxt = miiph_pkg::MIIPH_IDLE;
               else if (!LINE_RX_ERROR)
                  st_nxt = miiph_pkg::MIIPH_DATA;
            default:
               st_nxt = miiph_pkg::MIIPH_IDLE;
         endcase
         rxdv_nxt = (st_nxt != miiph_pkg::MIIPH_IDLE);
         rxd_nxt = LINE_RX_VALID ? LINE_RX_NIBBLE : `MIIPH_NIB_RST;
         rxer_nxt = (st_nxt == miiph_pkg::MIIPH_ERR);
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         st_r <= miiph_pkg::MIIPH_IDLE;
         rxd_r <= `MIIPH_NIB_RST;
         rxdv_r <= 1'b0;
         rxer_r <= 1'b0;
         crs_r <= 1'b0;
         col_r <= 1'b0;
         clk_d_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         rxd_r <= rxd_nxt;
         rxdv_r <= rxdv_nxt;
         rxer_r <= rxer_nxt;
         crs_r <= crs_nxt;
         col_r <= col_nxt;
         clk_d_r <= rx_clk_i;
      end
   end

   assign RXD = rxd_r;
   assign RX_DV = rxdv_r;
   assign RX_ER = rxer_r;
   assign COL = col_r;
   assign CRS = crs_r;
endmodule : miiph_top

// *** miiph_monitor.sv ***
/* Port checks for the MII data path, bound into miiph_top.
   Assumes SPEED_100 only changes while RST_N is low. */
`timescale 1ns/1ps
module miiph_monitor
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic SPEED_100,
   input wire logic FULL_DUPLEX,
   input wire logic TX_CLK,
   input wire logic RX_CLK,
   input wire logic RX_DV,
   input wire logic RX_ER,
   input wire logic COL,
   input wire logic CRS,
   input wire logic LINE_CARRIER,
   input wire logic LINE_COLLISION
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);
   a_slow_tx_clk: assert property (!SPEED_100 && $rose(TX_CLK) |->
      TX_CLK[*8] ##1 !TX_CLK[*8] ##1 TX_CLK) else $error("tx clock period");
   a_rx_clk_same: assert property (RX_CLK == TX_CLK) else $error("rx clock");
   a_fast_tx_clk: assert property (SPEED_100[*7] |-> TX_CLK != $past(TX_CLK))
      else $error("fast tx clock");
   a_col_follows: assert property (!FULL_DUPLEX[*7] |=> COL == $past(LINE_COLLISION))
      else $error("collision");
   a_col_masked: assert property (FULL_DUPLEX[*7] |-> !COL) else $error("col full");
   a_crs_rises: assert property (LINE_CARRIER |=> CRS) else $error("crs late");
   a_crs_own_tx: assert property ((FULL_DUPLEX[*7] ##0 (!LINE_CARRIER && !CRS)) |=> !CRS)
      else $error("crs on tx");
   a_crs_falls: assert property (FULL_DUPLEX && $fell(CRS) |-> !$past(RX_CLK) &&
      ($past(RX_CLK, 2) || $past(RX_CLK, 3))) else $error("crs fall");
   a_err_valid: assert property (RX_ER |-> RX_DV) else $error("rx error");
endmodule : miiph_monitor
bind miiph_top miiph_monitor u_mon (.*);

// *** miiph_mac_model.sv ***
/* MAC on the transmit pins: sends n_nib nibbles 1,2,3.. per frame.
   Assumes n_nib returns to zero between frames. */
`timescale 1ns/1ps
module miiph_mac_model
(
   input wire logic tx_clk,
   input wire logic [3:0] n_nib,
   output logic tx_en,
   output logic [3:0] txd
);
   logic [3:0] cnt = 4'h0;
   initial tx_en = 1'b0;
   initial txd = 4'h5;
   always @(posedge tx_clk)
   begin
      tx_en <= (cnt < n_nib);
      txd <= (cnt < n_nib) ? cnt + 4'h1 : ~txd;
      cnt <= (n_nib == 4'h0) ? 4'h0 : cnt + ((cnt < n_nib) ? 4'h1 : 4'h0);
   end
endmodule : miiph_mac_model

// *** tb_mii_phy_data_interface.sv ***
/* Bench for miiph_top at 10 Mbps, then a 100 Mbps clock check, with a MAC model on the transmit pins.
   Assumes the line side is driven here. */
`timescale 1ns/1ps
module tb_mii_phy_data_interface;
   logic clk = 1'b0, rst_n = 1'b0, fd = 1'b0, lrv = 1'b0, lre = 1'b0, lc = 1'b0;
   logic lcol = 1'b0, spd = 1'b0, txc, txen, dv, er, col, crs, ltv, lta, rxc;
   logic [3:0] txd, rxd, ltn, lrn = 4'h0, n_nib = 4'h0;
   int err_total = 0;
   int n_tests = 0;
   miiph_top u_dut (.SYS_CLK(clk), .RST_N(rst_n), .SPEED_100(spd), .FULL_DUPLEX(fd),
      .TX_CLK(txc), .TX_EN(txen), .TXD(txd), .RX_CLK(rxc), .RXD(rxd), .RX_DV(dv),
      .RX_ER(er), .COL(col), .CRS(crs), .LINE_TX_NIBBLE(ltn), .LINE_TX_VALID(ltv),
      .LINE_TX_ACTIVE(lta), .LINE_RX_NIBBLE(lrn), .LINE_RX_VALID(lrv),
      .LINE_RX_ERROR(lre), .LINE_CARRIER(lc), .LINE_COLLISION(lcol));
   miiph_mac_model u_mac (.tx_clk(txc), .n_nib(n_nib), .tx_en(txen), .txd(txd));
   task close_out;
      $display("errors %0d checks %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task chk(input logic [3:0] got, input logic [3:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task t_rx;
      int i;
      @(posedge clk);
      lrn <= 4'hc;
      lre <= 1'b1;
      lrv <= 1'b1;
      for (i = 0; i < 40 && dv !== 1'b1; i++)
         @(negedge clk);
      if (i == 40)
      begin
         err_total++;
         close_out();
      end
      chk(rxd, 4'hc);
      chk(er, 1'b1);
      @(posedge clk);
      lrv <= 1'b0;
      lre <= 1'b0;
      cyc(40);
      chk(rxd, 4'h0);
      chk(dv, 1'b0);
   endtask : t_rx
   task t_col;
      @(posedge clk);
      lcol <= 1'b1;
      cyc(3);
      chk(col, 1'b1);
      @(posedge clk);
      fd <= 1'b1;
      cyc(7);
      chk(col, 1'b0);
      @(posedge clk);
      lcol <= 1'b0;
      fd <= 1'b0;
   endtask : t_col
   task t_crs;
      @(posedge clk);
      fd <= 1'b1;
      lc <= 1'b1;
      cyc(2);
      chk(crs, 1'b1);
      @(posedge clk);
      lc <= 1'b0;
      cyc(1);
      chk(crs, 1'b1);
      cyc(20);
      chk(crs, 1'b0);
   endtask : t_crs
   task t_tx(input logic dup);
      logic [3:0] e;
      e = 4'h1;
      @(posedge clk);
      fd <= dup;
      n_nib <= 4'h3;
      repeat (160)
      begin
         @(negedge clk);
         if (ltv === 1'b1)
         begin
            chk(ltn, e);
            chk(crs, !dup);
            chk(lta, 1'b1);
            e++;
         end
      end
      chk(e, 4'h4);
      chk(lta, 1'b0);
      @(posedge clk);
      n_nib <= 4'h0;
      cyc(40);
   endtask : t_tx
   task t_fast;
      logic p;
      @(posedge clk);
      rst_n <= 1'b0;
      spd <= 1'b1;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      cyc(8);
      p = txc;
      cyc(1);
      chk(txc, !p);
      chk(rxc, txc);
   endtask : t_fast
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_rx();
      t_col();
      t_crs();
      t_tx(1'b0);
      t_tx(1'b1);
      t_fast();
      close_out();
   end
endmodule : tb_mii_phy_data_interface
